// *** design/dadc_consts.svh ***
// constant macros of the dual converter receive path control
`ifndef DADC_CONSTS_SVH
`define DADC_CONSTS_SVH

// sample and correction geometry
`define DADC_SAMPLE_W 12
`define DADC_STAGES 8
`define DADC_STAGE_W 2
`define DADC_FLASH_W 3
`define DADC_RAW_W 19
`define DADC_LATENCY 5
`define DADC_VALID_W 3
`define DADC_PERIOD_W 8

// timing: sys clock period, stabilizer lock and reference wake-up
`define DADC_CLK_NS 40
`define DADC_DCS_LOCK_NS 3000
`define DADC_DCS_LOCK_CYC ((`DADC_DCS_LOCK_NS + `DADC_CLK_NS - 1) / `DADC_CLK_NS)
`define DADC_LOCK_W 7
`define DADC_WAKE_MS 5
`define DADC_WAKE_CYC ((`DADC_WAKE_MS * 1000000 + `DADC_CLK_NS - 1) / `DADC_CLK_NS)
`define DADC_WAKE_W 17

// register bus geometry and map
`define DADC_ADDR_W 4
`define DADC_DATA_W 8
`define DADC_ADDR_STBY 4'h3
`define DADC_ADDR_PD_A 4'h4
`define DADC_ADDR_PD_B 4'h5
`define DADC_ADDR_DCS_A 4'h6
`define DADC_ADDR_DCS_B 4'h7
`define DADC_ADDR_STAT 4'h8

// field positions
`define DADC_BIT_STBY_A 0
`define DADC_BIT_STBY_B 1
`define DADC_BIT_PD 0
`define DADC_BIT_BG_OFF 1
`define DADC_BIT_DCS 0
`define DADC_BIT_ST_VALID 0
`define DADC_BIT_ST_LOCK_A 1
`define DADC_BIT_ST_LOCK_B 2
`define DADC_BIT_ST_WAKE 3
`define DADC_BIT_ST_PATH 4
`define DADC_BIT_ST_REFDN 5

`endif

// *** design/dadc_pkg.sv ***
// types of the dual converter receive path control
`default_nettype none
`include "dadc_consts.svh"

package dadc_pkg;

	typedef logic [`DADC_SAMPLE_W-1:0] dadc_sample_t;
	typedef logic [`DADC_RAW_W-1:0] dadc_raw_t;

	typedef struct packed {
		logic stbyA;
		logic stbyB;
		logic pdA;
		logic pdB;
		logic bgOff;
		logic dcsEnA;
		logic dcsEnB;
		logic sclkPrev;
		logic intClk;
		logic biasHalf;
		logic refDownPrev;
		logic chOnPrevA;
		logic chOnPrevB;
		logic [`DADC_PERIOD_W-1:0] periodCnt;
		logic [`DADC_PERIOD_W-1:0] period;
		logic [`DADC_PERIOD_W-1:0] phaseCnt;
		logic [`DADC_LOCK_W-1:0] lockCntA;
		logic [`DADC_LOCK_W-1:0] lockCntB;
		logic [`DADC_VALID_W-1:0] validCnt;
		logic [`DADC_WAKE_W-1:0] wakeCnt;
		logic [`DADC_SAMPLE_W-1:0] corrA;
		logic [`DADC_SAMPLE_W-1:0] corrB;
		logic [`DADC_DATA_W-1:0] rdData;
	} dadc_state_t;

endpackage

`default_nettype wire

// *** design/dadc_sample_delay.sv ***
// sample delay memory: fixed-depth shift store with registered output
`timescale 1ns/1ps
`default_nettype none

module dadc_sample_delay
#(
	parameter int WIDTH = 24,
	parameter int DEPTH = 5
)
(
	input wire logic clock, // system clock
	input wire logic rst, // asynchronous reset, high
	input wire logic shiftEn, // advance one sampling cycle
	input wire logic [WIDTH-1:0] wrData, // word entering the delay
	output logic [WIDTH-1:0] rdData // word leaving, registered
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] stage;
	} dadc_delay_st_t;

	dadc_delay_st_t st_ff;
	dadc_delay_st_t nxt_st;

	// shift on each sampling edge only, so depth counts samples
	always_comb
	begin
		nxt_st = st_ff;
		if (shiftEn)
		begin
			nxt_st.stage[0] = wrData;
			for (int i = 1; i < DEPTH; i++)
			begin
				nxt_st.stage[i] = st_ff.stage[i-1];
			end
		end
	end

	// state register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rdData = st_ff.stage[DEPTH-1];

endmodule // dadc_sample_delay

`default_nettype wire

// *** design/dadc_rx_ctrl.sv ***
// dual converter receive path control: capture, correction, latency, power
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.svh"

// Summary of operation
// R1 - capture both channels on the falling edge of one shared sampling clock
// R2 - each corrected sample appears at outputs five sampling cycles after capture
// R3 - combine stage codes, correct redundancy, deliver a 12 bit result per channel
// R4 - one stabilizer per channel regenerates the non-sampling edge at half period; the code shares one phase counter between both channels
// R5 - writing one to registers 6 and 7 enables the channel stabilizers
// R6 - software enables stabilizers only for sampling rates above 40 MHz
// R7 - after a rate change, allow about three microseconds for stabilizer lock
// R8 - low bias pin halves converter bias currents
// R9 - registers 3, 4 and 5 put each channel in standby independently
// R10 - both channels fully powered down also powers down the references
// R11 - after full power-down wake, software waits about five milliseconds
// R12 - a register bit switches off the internal bandgap for an external reference
// R13 - in half duplex the unused receive data path is disabled automatically
// R14 - data valid stays low after reset, wake or relock until latency elapses
module dadc_rx_ctrl
	import dadc_pkg::*;
#(
	parameter int WAKE_CYCLES = `DADC_WAKE_CYC,
	parameter int LATENCY = `DADC_LATENCY
)
(
	input wire logic clock, // system clock, 25 MHz
	input wire logic rst, // asynchronous reset, high
	input wire logic [`DADC_ADDR_W-1:0] regAddr, // register address
	input wire logic [`DADC_DATA_W-1:0] regWrData, // register write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [`DADC_DATA_W-1:0] regRdData, // read data, cycle after strobe
	input wire logic sampleClk, // shared sampling clock level
	input wire dadc_pkg::dadc_raw_t rawA, // stage codes of channel a
	input wire dadc_pkg::dadc_raw_t rawB, // stage codes of channel b
	input wire logic converterLowBiasPin, // low power bias request
	input wire logic halfDuplex, // interface runs half duplex
	input wire logic txOwnsBus, // in half duplex, bus carries transmit
	output dadc_pkg::dadc_sample_t dataA, // channel a sample
	output dadc_pkg::dadc_sample_t dataB, // channel b sample
	output logic dataValid, // samples at outputs are valid
	output logic sampleStrobe, // one pulse per sample advance
	output logic intClkA, // channel a internal clock
	output logic intClkB, // channel b internal clock
	output logic convOnA, // channel a converter running
	output logic convOnB, // channel b converter running
	output logic biasHalf, // bias currents cut to half
	output logic refPowerDown, // internal references off
	output logic bandgapOn, // internal bandgap running
	output logic rxPathEn // receive digital path enabled
);

	dadc_state_t st_ff;
	dadc_state_t nxt_st;

	logic sclkFall;
	logic captureEn;
	logic chOnA;
	logic chOnB;
	logic bothDown;
	logic pathOn;
	logic lockedA;
	logic lockedB;
	logic wakeBusy;
	logic rateChange;
	logic restartValid;
	logic [`DADC_DATA_W-1:0] statusWord;
	logic [`DADC_SAMPLE_W-1:0] fixA;
	logic [`DADC_SAMPLE_W-1:0] fixB;
	logic [2*`DADC_SAMPLE_W-1:0] pipeOut;

	// counts sized to their registers; a longer lock time needs a wider counter
	localparam logic [`DADC_LOCK_W-1:0] LOCK_CYC = `DADC_LOCK_W'(`DADC_DCS_LOCK_CYC);
	localparam logic [`DADC_WAKE_W-1:0] WAKE_CYC = `DADC_WAKE_W'(WAKE_CYCLES);
	localparam logic [`DADC_VALID_W-1:0] VALID_AT = `DADC_VALID_W'(LATENCY + 1);

	// redundant stage codes overlap by one bit; the sum removes flash errors
	// stage k weighs 2^(10-k); the last flash word lands in the lowest bits
	function automatic logic [`DADC_SAMPLE_W-1:0] correctCode(input dadc_raw_t raw);
		logic [`DADC_SAMPLE_W+1:0] acc;
		acc = '0;
		for (int k = 0; k < `DADC_STAGES; k++)
		begin
			acc = acc + ((`DADC_SAMPLE_W+2)'(raw[`DADC_STAGE_W*k +: `DADC_STAGE_W])
				<< (`DADC_SAMPLE_W - 2 - k));
		end
		acc = acc + (`DADC_SAMPLE_W+2)'(raw[`DADC_RAW_W-1 -: `DADC_FLASH_W]);
		// clamp instead of wrap when the top stages over-range
		if (acc[`DADC_SAMPLE_W+1:`DADC_SAMPLE_W] != 2'h0)
			correctCode = {`DADC_SAMPLE_W{1'b1}};
		else
			correctCode = acc[`DADC_SAMPLE_W-1:0];
	endfunction

	// differs by more than one count; one count of slip is sampling noise
	function automatic logic periodMoved(input logic [`DADC_PERIOD_W-1:0] a,
		input logic [`DADC_PERIOD_W-1:0] b);
		logic [`DADC_PERIOD_W-1:0] d;
		d = (a > b) ? (a - b) : (b - a);
		periodMoved = (d > `DADC_PERIOD_W'(1));
	endfunction

	// channel power state from standby and power-down bits
	// standby and full power-down look alike to the digital side
	// R9 independent standby
	assign chOnA = !(st_ff.stbyA || st_ff.pdA);
	assign chOnB = !(st_ff.stbyB || st_ff.pdB);
	// R10 references follow full power-down of both
	// one channel down alone keeps the shared references running
	assign bothDown = st_ff.pdA && st_ff.pdB;
	// R13 half duplex drops the idle receive path
	// levels only, so a bus turnaround takes effect in the same cycle
	assign pathOn = !(halfDuplex && txOwnsBus);

	// R1 one falling edge captures both channels
	// the previous level is the sampled level one system clock back
	assign sclkFall = st_ff.sclkPrev && !sampleClk;
	// with the path off captures stop, so the pipe keeps its words
	assign captureEn = sclkFall && pathOn;

	// stabilizer lock status per channel
	assign lockedA = (st_ff.lockCntA == '0);
	assign lockedB = (st_ff.lockCntB == '0);
	assign wakeBusy = (st_ff.wakeCnt != '0);
	// a change is seen only at the fall that ends the odd period
	assign rateChange = sclkFall && (st_ff.period != '0) && periodMoved(st_ff.periodCnt, st_ff.period);

	// R3 per-channel error correction
	// both channels corrected every cycle; only a capture edge keeps the result
	assign fixA = correctCode(rawA);
	assign fixB = correctCode(rawB);

	// R14 anything that makes the pipe contents untrustworthy restarts the count
	assign restartValid = !pathOn
		|| !(chOnA || chOnB)
		|| (chOnA && !st_ff.chOnPrevA)
		|| (chOnB && !st_ff.chOnPrevB)
		|| (st_ff.dcsEnA && !lockedA)
		|| (st_ff.dcsEnB && !lockedB);

	// status byte for the read port; unused upper bits read zero
	assign statusWord[`DADC_BIT_ST_VALID] = (st_ff.validCnt == VALID_AT);
	assign statusWord[`DADC_BIT_ST_LOCK_A] = lockedA;
	assign statusWord[`DADC_BIT_ST_LOCK_B] = lockedB;
	assign statusWord[`DADC_BIT_ST_WAKE] = wakeBusy;
	assign statusWord[`DADC_BIT_ST_PATH] = pathOn;
	assign statusWord[`DADC_BIT_ST_REFDN] = bothDown;
	assign statusWord[`DADC_DATA_W-1:`DADC_BIT_ST_REFDN+1] = '0;

	// next-state logic for the whole block
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sclkPrev = sampleClk;
		// R8 bias follows the low power pin
		nxt_st.biasHalf = converterLowBiasPin;
		nxt_st.refDownPrev = bothDown;
		nxt_st.chOnPrevA = chOnA;
		nxt_st.chOnPrevB = chOnB;

		// register writes
		// unmapped and status writes land in default and change nothing
		if (regWr)
		begin
			unique case (regAddr)
				// R9 standby bits of both channels
				`DADC_ADDR_STBY:
				begin
					nxt_st.stbyA = regWrData[`DADC_BIT_STBY_A];
					nxt_st.stbyB = regWrData[`DADC_BIT_STBY_B];
				end
				// R9 full power-down of channel a
				`DADC_ADDR_PD_A:
					nxt_st.pdA = regWrData[`DADC_BIT_PD];
				// R12 bandgap switch sits beside channel b power-down
				`DADC_ADDR_PD_B:
				begin
					nxt_st.pdB = regWrData[`DADC_BIT_PD];
					nxt_st.bgOff = regWrData[`DADC_BIT_BG_OFF];
				end
				// R5 stabilizer enables
				`DADC_ADDR_DCS_A:
					nxt_st.dcsEnA = regWrData[`DADC_BIT_DCS];
				`DADC_ADDR_DCS_B:
					nxt_st.dcsEnB = regWrData[`DADC_BIT_DCS];
				default:
				begin
				end
			endcase
		end

		// read data stands one cycle only, zero otherwise
		nxt_st.rdData = '0;
		if (regRd)
		begin
			unique case (regAddr)
				`DADC_ADDR_STBY:
				begin
					nxt_st.rdData[`DADC_BIT_STBY_A] = st_ff.stbyA;
					nxt_st.rdData[`DADC_BIT_STBY_B] = st_ff.stbyB;
				end
				`DADC_ADDR_PD_A:
					nxt_st.rdData[`DADC_BIT_PD] = st_ff.pdA;
				`DADC_ADDR_PD_B:
				begin
					nxt_st.rdData[`DADC_BIT_PD] = st_ff.pdB;
					nxt_st.rdData[`DADC_BIT_BG_OFF] = st_ff.bgOff;
				end
				`DADC_ADDR_DCS_A:
					nxt_st.rdData[`DADC_BIT_DCS] = st_ff.dcsEnA;
				`DADC_ADDR_DCS_B:
					nxt_st.rdData[`DADC_BIT_DCS] = st_ff.dcsEnB;
				`DADC_ADDR_STAT:
					nxt_st.rdData = statusWord;
				default:
				begin
				end
			endcase
		end

		// period measured in system cycles between falling edges
		// saturates at full count, so a stopped clock reads as one long period
		if (sclkFall)
		begin
			nxt_st.period = st_ff.periodCnt;
			nxt_st.periodCnt = `DADC_PERIOD_W'(1);
		end
		else if (st_ff.periodCnt != '1)
		begin
			nxt_st.periodCnt = st_ff.periodCnt + `DADC_PERIOD_W'(1);
		end

		// R4 regenerate the rising edge half a period after sampling
		// one phase counter serves both channels, since they share the clock
		if (sclkFall)
		begin
			nxt_st.intClk = 1'b0;
			nxt_st.phaseCnt = `DADC_PERIOD_W'(1);
		end
		else
		begin
			if (st_ff.phaseCnt != '1)
				nxt_st.phaseCnt = st_ff.phaseCnt + `DADC_PERIOD_W'(1);
			if (st_ff.phaseCnt >= (st_ff.period >> 1))
				nxt_st.intClk = 1'b1;
		end

		// R7 lock timer restarts on enable or rate change
		// a plain timer stands in for the loop; it cannot see real lock
		if ((st_ff.dcsEnA && rateChange) || (nxt_st.dcsEnA && !st_ff.dcsEnA))
			nxt_st.lockCntA = LOCK_CYC;
		else if (!st_ff.dcsEnA)
			nxt_st.lockCntA = '0;
		else if (!lockedA)
			nxt_st.lockCntA = st_ff.lockCntA - `DADC_LOCK_W'(1);
		// channel b timer mirrors channel a
		if ((st_ff.dcsEnB && rateChange) || (nxt_st.dcsEnB && !st_ff.dcsEnB))
			nxt_st.lockCntB = LOCK_CYC;
		else if (!st_ff.dcsEnB)
			nxt_st.lockCntB = '0;
		else if (!lockedB)
			nxt_st.lockCntB = st_ff.lockCntB - `DADC_LOCK_W'(1);

		// R11 reference recharge timer after leaving full power-down
		// informational only: valid does not wait, the long recharge is software's
		if (st_ff.refDownPrev && !bothDown)
			nxt_st.wakeCnt = WAKE_CYC;
		else if (bothDown)
			nxt_st.wakeCnt = '0;
		else if (wakeBusy)
			nxt_st.wakeCnt = st_ff.wakeCnt - `DADC_WAKE_W'(1);

		// R3 aligned pair of corrected words; a sleeping channel gives zero
		if (captureEn)
		begin
			nxt_st.corrA = chOnA ? fixA : '0;
			nxt_st.corrB = chOnB ? fixB : '0;
		end

		// R14 valid restarts after reset, wake, relock or path loss
		if (restartValid)
			nxt_st.validCnt = '0;
		else if (captureEn && st_ff.validCnt != VALID_AT)
			nxt_st.validCnt = st_ff.validCnt + `DADC_VALID_W'(1);
	end

	// state register; the sampling clock level is assumed low at reset
	// a high level at release looks like a rising edge only, so no false capture follows
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// R2 five-sample delay behind the correction register
	// the correction register holds a word until the next capture, so depth equals latency
	dadc_sample_delay #(
		.WIDTH(2*`DADC_SAMPLE_W),
		.DEPTH(LATENCY)
	) u_delay (
		.clock(clock),
		.rst(rst),
		.shiftEn(captureEn),
		.wrData({st_ff.corrA, st_ff.corrB}),
		.rdData(pipeOut)
	);

	// sample outputs straight from the delay registers
	// upper half of the delay word is channel a
	assign dataA = pipeOut[2*`DADC_SAMPLE_W-1:`DADC_SAMPLE_W];
	assign dataB = pipeOut[`DADC_SAMPLE_W-1:0];
	assign dataValid = (st_ff.validCnt == VALID_AT);
	// combinational so the back end sees the advance in its own cycle
	assign sampleStrobe = captureEn;
	// zero outside the answer cycle
	assign regRdData = st_ff.rdData;
	// R4 stabilized clock only where enabled, raw clock otherwise
	// passthrough keeps a disabled stabilizer out of the clock path
	assign intClkA = st_ff.dcsEnA ? st_ff.intClk : sampleClk;
	assign intClkB = st_ff.dcsEnB ? st_ff.intClk : sampleClk;
	assign convOnA = chOnA;
	assign convOnB = chOnB;
	// registered one cycle behind the pin
	assign biasHalf = st_ff.biasHalf;
	// R10 reference power-down
	assign refPowerDown = bothDown;
	// R12 bandgap off by request or with the references
	assign bandgapOn = !(st_ff.bgOff || bothDown);
	assign rxPathEn = pathOn;

endmodule // dadc_rx_ctrl

`default_nettype wire

// *** tb/dadc_rx_ctrl_sva.sv ***
// port checker of the receive path control
`timescale 1ns/1ps
`default_nettype none
module dadc_rx_ctrl_sva
	import dadc_pkg::*;
#(
	parameter int WAKE_CYCLES = 20,
	parameter int LATENCY = 5
)
(
	input wire logic clock, // system clock
	input wire logic rst, // reset
	input wire logic regRd, // read strobe
	input wire logic [7:0] regRdData, // read data
	input wire logic sampleClk, // sampling clock
	input wire logic converterLowBiasPin, // bias pin
	input wire logic halfDuplex, // half duplex
	input wire logic txOwnsBus, // bus to transmit
	input wire dadc_pkg::dadc_sample_t dataA, // sample a
	input wire dadc_pkg::dadc_sample_t dataB, // sample b
	input wire logic dataValid, // valid
	input wire logic sampleStrobe, // capture pulse
	input wire logic convOnA, // channel a on
	input wire logic convOnB, // channel b on
	input wire logic biasHalf, // bias halved
	input wire logic refPowerDown, // references off
	input wire logic bandgapOn, // bandgap on
	input wire logic rxPathEn // path enabled
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// read port and power relations
	chk_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data not idle");
	chk_path_comb: assert property (rxPathEn == !(halfDuplex && txOwnsBus))
		else $error("path enable wrong");
	chk_path_valid: assert property ((!rxPathEn)[*2] |-> !dataValid)
		else $error("valid with path off");
	chk_bias_follow: assert property (1'b1 |=> biasHalf == $past(converterLowBiasPin))
		else $error("bias does not follow pin");
	chk_ref_down: assert property (refPowerDown |-> !bandgapOn && !convOnA && !convOnB)
		else $error("references on in power down");
	// capture timing and validity
	chk_strobe_edge: assert property (sampleStrobe |-> !sampleClk && $past(sampleClk) && rxPathEn)
		else $error("capture off the falling edge");
	chk_data_hold: assert property (!sampleStrobe |=> $stable(dataA) && $stable(dataB))
		else $error("data moved without capture");
	chk_valid_rise: assert property ($rose(dataValid) |-> $past(sampleStrobe))
		else $error("valid rose off a capture");
	chk_valid_off: assert property ((!convOnA && !convOnB)[*2] |-> !dataValid)
		else $error("valid with both channels off");
endmodule // dadc_rx_ctrl_sva

bind dadc_rx_ctrl dadc_rx_ctrl_sva #(.WAKE_CYCLES(WAKE_CYCLES), .LATENCY(LATENCY)) chk (
	.clock(clock), .rst(rst), .regRd(regRd), .regRdData(regRdData), .sampleClk(sampleClk),
	.converterLowBiasPin(converterLowBiasPin), .halfDuplex(halfDuplex), .txOwnsBus(txOwnsBus),
	.dataA(dataA), .dataB(dataB), .dataValid(dataValid), .sampleStrobe(sampleStrobe),
	.convOnA(convOnA), .convOnB(convOnB), .biasHalf(biasHalf), .refPowerDown(refPowerDown),
	.bandgapOn(bandgapOn), .rxPathEn(rxPathEn));
`default_nettype wire

// *** tb/dadc_clk_src.sv ***
// sampling clock source standing at the far side
`timescale 1ns/1ps
`default_nettype none
module dadc_clk_src
#(
	parameter int HALF = 3
)
(
	input wire logic clock, // system clock
	input wire logic rst, // reset
	input wire logic run, // clock running
	input wire logic slow, // double the period
	output logic sampleClk // shared sampling clock
);
	int cnt;
	// rate change forces relock; rate here sits below the stabilizer range, only lock timing matters
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			sampleClk <= 1'b0;
		end
		else if (run)
		begin
			if (cnt >= (slow ? 2 * HALF : HALF) - 1)
			begin
				cnt <= 0;
				sampleClk <= !sampleClk;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule // dadc_clk_src
`default_nettype wire

// *** tb/dadc_rx_ctrl_tb_top.sv ***
// self-checking bench of the receive path control
`timescale 1ns/1ps
`default_nettype none
module dadc_rx_ctrl_tb_top;
	import dadc_pkg::*;
	localparam int WAKE = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic lowBias = 1'b0;
	logic halfDuplex = 1'b0;
	logic txOwnsBus = 1'b0;
	logic run = 1'b0;
	logic slow = 1'b0;
	logic rdSeen = 1'b0;
	logic newRaw = 1'b0;
	dadc_raw_t rawA = '0;
	dadc_raw_t rawB = '0;
	logic sampleClk, dataValid, sampleStrobe, intClkA, intClkB, convOnA, convOnB;
	logic biasHalf, refPowerDown, bandgapOn, rxPathEn;
	logic [7:0] regRdData;
	dadc_sample_t dataA, dataB;
	logic [7:0] sh [16];
	logic [18:0] pool [128];
	logic [7:0] rq [$];
	logic [23:0] sq [$];
	int pi = 0;
	int badCount = 0;
	int nTests = 0;
	int hiCnt = 0;

	// system clock
	always #20 clock = !clock;

	dadc_rx_ctrl #(.WAKE_CYCLES(WAKE)) uut (
		.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .sampleClk(sampleClk), .rawA(rawA), .rawB(rawB),
		.converterLowBiasPin(lowBias), .halfDuplex(halfDuplex), .txOwnsBus(txOwnsBus),
		.dataA(dataA), .dataB(dataB), .dataValid(dataValid), .sampleStrobe(sampleStrobe),
		.intClkA(intClkA), .intClkB(intClkB), .convOnA(convOnA), .convOnB(convOnB),
		.biasHalf(biasHalf), .refPowerDown(refPowerDown), .bandgapOn(bandgapOn), .rxPathEn(rxPathEn));

	dadc_clk_src #(.HALF(3)) src (.clock(clock), .rst(rst), .run(run), .slow(slow), .sampleClk(sampleClk));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			badCount++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
		if (a >= 4'h3 && a <= 4'h7)
			sh[a] = d;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		rq.push_back(e);
		@(posedge clock);
		regRd <= 1'b0;
	endtask

	// corrected code: weighted stage sum plus flash, clamped at full scale
	function automatic logic [11:0] corr(input dadc_raw_t r);
		int s;
		s = int'(r[18:16]);
		for (int k = 0; k < 8; k++)
			s += int'(r[2*k +: 2]) << (10 - k);
		return (s > 4095) ? 12'hfff : 12'(s);
	endfunction

	// new stage codes right after each capture edge
	always @(posedge clock)
	begin
		rdSeen <= regRd;
		if (newRaw)
		begin
			rawA <= pool[pi % 128];
			rawB <= pool[(pi + 37) % 128];
			pi++;
			newRaw = 1'b0;
		end
	end

	// observer: the queue mirrors the pipeline, oldest note leaves as its word shows
	always @(negedge clock)
	begin
		if (rdSeen)
			check(regRdData, rq.pop_front());
		if (sampleStrobe === 1'b1)
		begin
			if (sq.size() == 6)
			begin
				if (dataValid === 1'b1)
				begin
					check(dataA, sq[0][23:12]);
					check(dataB, sq[0][11:0]);
				end
				void'(sq.pop_front());
			end
			sq.push_back({(sh[3][0] | sh[4][0]) ? 12'h000 : corr(rawA), (sh[3][1] | sh[5][0]) ? 12'h000 : corr(rawB)});
			newRaw = 1'b1;
		end
		if (sh[6][0] === 1'b0)
			check(intClkA, sampleClk);
		if (sh[7][0] === 1'b0)
			check(intClkB, sampleClk);
	end

	// main sequence
	initial
	begin
		void'($urandom(38));
		for (int i = 0; i < 128; i++)
			pool[i] = 19'($urandom());
		for (int i = 0; i < 16; i++)
			sh[i] = 8'h00;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int a = 3; a < 9; a++)
			rd(4'(a), (a == 8) ? 8'h16 : 8'h00);
		wr(4'h8, 8'hff);
		rd(4'h8, 8'h16);
		rd(4'hf, 8'h00);
		@(negedge clock);
		check({convOnA, convOnB, bandgapOn, refPowerDown}, 4'b1110);
		run <= 1'b1;
		repeat (200) @(posedge clock);
		@(negedge clock);
		check(dataValid, 1'b1);
		// standby of a alone, b alone, then both back
		for (int i = 0; i < 3; i++)
		begin
			wr(4'h3, 8'((i + 1) % 3));
			repeat (60) @(posedge clock);
			@(negedge clock);
			check({convOnA, convOnB}, {~sh[3][0], ~sh[3][1]});
			rd(4'h3, sh[3]);
		end
		wr(4'h4, 8'h01);
		wr(4'h5, 8'h01);
		repeat (4) @(posedge clock);
		rd(4'h8, 8'h36);
		@(negedge clock);
		check({refPowerDown, bandgapOn, dataValid}, 3'b100);
		wr(4'h4, 8'h00);
		repeat (2) @(posedge clock);
		rd(4'h8, 8'h1e);
		repeat (WAKE + 100) @(posedge clock);
		rd(4'h8, 8'h17);
		wr(4'h5, 8'h02);
		@(negedge clock);
		check({bandgapOn, refPowerDown}, 2'b00);
		rd(4'h5, 8'h02);
		wr(4'h5, 8'h00);
		@(posedge clock);
		lowBias <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		check(biasHalf, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock);
			{halfDuplex, txOwnsBus} <= 2'(i);
			@(negedge clock);
			check(rxPathEn, i != 3);
		end
		repeat (3) @(negedge clock);
		check(dataValid, 1'b0);
		@(posedge clock);
		{halfDuplex, txOwnsBus} <= 2'b00;
		repeat (100) @(posedge clock);
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h01);
		repeat (3) @(posedge clock);
		rd(4'h8, 8'h10);
		repeat (150) @(posedge clock);
		rd(4'h8, 8'h17);
		@(posedge clock);
		slow <= 1'b1;
		repeat (40) @(posedge clock);
		rd(4'h8, 8'h10);
		repeat (250) @(posedge clock);
		rd(4'h8, 8'h17);
		// both regenerated clocks, summed over two slow periods, spend half the time high
		repeat (24)
		begin
			@(negedge clock);
			hiCnt += intClkA + intClkB;
		end
		check(hiCnt, 32'd24);
		repeat (4) @(posedge clock);
		summarize();
	end

	// watchdog, the sequence needs about 1200 cycles
	initial
	begin
		#(40 * 20000);
		badCount++;
		summarize();
	end
endmodule // dadc_rx_ctrl_tb_top
`default_nettype wire
